// [design/dnca_arbiter.sv]
// Network control arbiter of a motor drive: query response policy,
// run and reference source arbitration, reset and override, counters.
// Assumes a frame decoder presents one pulse per received query with
// its error flags and decoded object write, and Avalon-MM register access.
//
// Behaviour
// - Error-free serviceable query gets a normal response, unless broadcast.
// - Parity or CRC error: query discarded, no response.
// - Non-existent coil or register: exception response with its code.
// - Local mode: console alone starts and stops; network run ignored.
// - Local mode speed reference follows the local reference selection.
// - Remote, run source terminals: terminal strip alone runs the motor.
// - Remote, run source network: forward and reverse run objects control.
// - Reset from terminals, internal functions and network always accepted.
// - Network reference selected: speed reference is the network value.
// - Override from network coil, or from terminal only when override terminal is enabled.
// - No override terminal and link lost: network override dropped.
// - Local or remote choice only from terminal strip, never network.
// - Network monitoring reads serviced in both local and remote mode.
// - Readable counters of the eight network message statistics.
// - Detect cards in either of two slots, then exchange their I/O.
// - Four card inputs each usable as level, edge and complement.
// - Enabled thermistor trips on high resistance and on short.
`timescale 1ns/1ps
`include "dnca_defines.svh"
module dnca_arbiter import dnca_pkg::*; #(
  parameter int MS_CYCLES = `DNCA_MS_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic q_valid,
  input wire logic q_parity_err,
  input wire logic q_crc_err,
  input wire logic q_broadcast,
  input wire logic q_func_ok,
  input wire logic q_addr_ok,
  input wire logic q_write,
  input wire logic [2:0] q_obj,
  input wire logic [15:0] q_wdata,
  input wire logic q_overrun,
  input wire logic q_buf_err,
  output logic rsp_normal,
  output logic rsp_exception,
  output logic [7:0] rsp_exc_code,
  input wire logic term_local,
  input wire logic console_run_fwd,
  input wire logic console_run_rev,
  input wire logic term_run_fwd,
  input wire logic term_run_rev,
  input wire logic [15:0] console_ref,
  input wire logic [15:0] analog_ref,
  input wire logic [15:0] option_ref,
  input wire logic term_reset,
  input wire logic internal_reset,
  input wire logic term_override,
  input wire logic [1:0] card_detect,
  input wire logic [7:0] card_di,
  input wire logic [31:0] card_th_ohms,
  output logic run_fwd,
  output logic run_rev,
  output logic [15:0] speed_ref,
  output logic drive_reset,
  output logic essential_services_override,
  output logic link_lost,
  output logic [7:0] station_address,
  output logic [3:0] baud_select,
  output logic [1:0] parity_select,
  output logic [1:0] card_present,
  output logic [7:0] card_di_level,
  output logic [7:0] card_di_rise,
  output logic [7:0] card_di_inv,
  output logic [1:0] overtemp_trip,
  output logic [1:0] short_trip
);
  dnca_top_t s_ff, nxt_s;
  logic recovered;
  logic q_ok;
  logic q_apply;
  logic [7:0] cnt_inc;
  logic [31:0] rd_c;
  logic [31:0] stat_c;
  logic [1:0] th_en;
  dnca_ref_t ref_sel;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Error-free query; writes act even on broadcast
  assign q_ok = q_valid & ~q_parity_err & ~q_crc_err;
  assign q_apply = q_ok & q_func_ok & q_addr_ok & q_write;

  assign th_en = {s_ff.cfg[`DNCA_CFG_TH_R], s_ff.cfg[`DNCA_CFG_TH_L]};

  dnca_link_watch #(
    .MS_CYCLES(MS_CYCLES)
  ) u_watch (
    .clock(clock),
    .nrst(nrst),
    .kick(q_ok),
    .timeout_ms(s_ff.timeout),
    .link_lost(link_lost),
    .recovered(recovered)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_slot
      dnca_opt_slot u_slot (
        .clock(clock),
        .nrst(nrst),
        .card_detect(card_detect[g]),
        .di(card_di[g*4 +: 4]),
        .th_ohms(card_th_ohms[g*16 +: 16]),
        .th_enable(th_en[g]),
        .trip_clear(s_ff.rst_req),
        .card_present(card_present[g]),
        .di_level(card_di_level[g*4 +: 4]),
        .di_rise(card_di_rise[g*4 +: 4]),
        .di_inv(card_di_inv[g*4 +: 4]),
        .overtemp_trip(overtemp_trip[g]),
        .short_trip(short_trip[g])
      );
    end
  endgenerate

  // Counter events, one bit per statistic
  always_comb begin
    cnt_inc = 8'h00;
    cnt_inc[`DNCA_C_RX] = q_valid;
    cnt_inc[`DNCA_C_ERR] = q_valid & (q_parity_err | q_crc_err);
    cnt_inc[`DNCA_C_EXC] = q_ok & ~q_broadcast & ~(q_func_ok & q_addr_ok);
    cnt_inc[`DNCA_C_SLV] = q_ok;
    cnt_inc[`DNCA_C_NORSP] = q_valid & (~q_ok | q_broadcast);
    cnt_inc[`DNCA_C_OVR] = q_overrun;
    cnt_inc[`DNCA_C_BUF] = q_buf_err;
    cnt_inc[`DNCA_C_REC] = recovered;
  end

  always_comb begin
    stat_c = 32'h0;
    stat_c[0] = link_lost;
    stat_c[1] = term_local;
    stat_c[2] = s_ff.ovr_active;
    stat_c[3] = s_ff.run_fwd;
    stat_c[4] = s_ff.run_rev;
    stat_c[6:5] = card_present;
    stat_c[8:7] = overtemp_trip;
    stat_c[10:9] = short_trip;
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_c = 32'h0;
    if (avs_address[7:5] == 3'(`DNCA_A_CNT >> 5) && avs_address[1:0] == 2'h0) begin
      rd_c = {16'h0, s_ff.cnt[avs_address[4:2]]};
    end else begin
      unique case (avs_address)
        `DNCA_A_CFG: rd_c = {24'h0, s_ff.cfg};
        `DNCA_A_LINK: rd_c = {16'h0, s_ff.timeout};
        `DNCA_A_SER: rd_c = {18'h0, s_ff.ser};
        `DNCA_A_STAT: rd_c = stat_c;
        `DNCA_A_SPD: rd_c = {16'h0, s_ff.speed_ref};
        `DNCA_A_DI: rd_c = {16'h0, card_di_rise, card_di_level};
        default: rd_c = 32'h0;
      endcase
    end
  end

  assign ref_sel = dnca_ref_t'(term_local ? s_ff.cfg[`DNCA_CFG_LREF +: 2] : s_ff.cfg[`DNCA_CFG_RREF +: 2]);

  always_comb begin
    logic [31:0] w;
    w = 32'h0;
    nxt_s = s_ff;
    nxt_s.rsp_norm = 1'h0;
    nxt_s.rsp_exc = 1'h0;
    nxt_s.rst_req = 1'h0;

    // Bus slave: one wait state, write lands when waitrequest is low
    unique case (s_ff.bus)
      DNCA_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_s.bus = DNCA_ANSWER;
          nxt_s.rdata = rd_c;
        end
      end
      DNCA_ANSWER: begin
        nxt_s.bus = DNCA_IDLE;
        if (avs_write) begin
          unique case (avs_address)
            `DNCA_A_CFG: begin
              w = be_merge({24'h0, s_ff.cfg}, avs_writedata, avs_byteenable);
              nxt_s.cfg = w[7:0];
              if (w[`DNCA_CFG_CLR]) begin
                nxt_s.cnt = '0;
              end
            end
            `DNCA_A_LINK: begin
              w = be_merge({16'h0, s_ff.timeout}, avs_writedata, avs_byteenable);
              nxt_s.timeout = w[15:0];
            end
            `DNCA_A_SER: begin
              w = be_merge({18'h0, s_ff.ser}, avs_writedata, avs_byteenable);
              nxt_s.ser = w[13:0];
            end
            default: w = 32'h0;
          endcase
        end
      end
    endcase

    // Query answer policy
    if (q_ok && !q_broadcast) begin
      if (!q_func_ok) begin
        nxt_s.rsp_exc = 1'h1;
        nxt_s.exc_code = `DNCA_EXC_ILL_FUNC;
      end else if (!q_addr_ok) begin
        nxt_s.rsp_exc = 1'h1;
        nxt_s.exc_code = `DNCA_EXC_ILL_ADDR;
      end else begin
        // Reads answered whatever the local or remote mode
        nxt_s.rsp_norm = 1'h1;
      end
    end

    // Network object writes
    if (q_apply) begin
      unique case (q_obj)
        DNCA_OBJ_RUN_FWD: nxt_s.net_fwd = q_wdata[0];
        DNCA_OBJ_RUN_REV: nxt_s.net_rev = q_wdata[0];
        DNCA_OBJ_OVR: nxt_s.net_ovr = q_wdata[0];
        DNCA_OBJ_RESET: nxt_s.rst_req = q_wdata[0];
        DNCA_OBJ_SPEED: nxt_s.net_ref = q_wdata;
        DNCA_OBJ_LOCREM: nxt_s.rst_req = 1'h0;
        default: nxt_s.rst_req = 1'h0;
      endcase
    end
    if (term_reset || internal_reset) begin
      nxt_s.rst_req = 1'h1;
    end

    // Without a wired override the coil cannot outlive the link
    if (link_lost && !s_ff.cfg[`DNCA_CFG_OVR_TERM]) begin
      nxt_s.net_ovr = 1'h0;
    end
    nxt_s.ovr_active = s_ff.net_ovr | (term_override & s_ff.cfg[`DNCA_CFG_OVR_TERM]);

    // Run source arbitration; local mode runs only from console
    if (term_local) begin
      nxt_s.run_fwd = console_run_fwd;
      nxt_s.run_rev = console_run_rev;
    end else if (s_ff.cfg[`DNCA_CFG_RUN_SRC]) begin
      nxt_s.run_fwd = s_ff.net_fwd;
      nxt_s.run_rev = s_ff.net_rev;
    end else begin
      nxt_s.run_fwd = term_run_fwd;
      nxt_s.run_rev = term_run_rev;
    end

    unique case (ref_sel)
      DNCA_REF_CONSOLE: nxt_s.speed_ref = console_ref;
      DNCA_REF_ANALOG: nxt_s.speed_ref = analog_ref;
      DNCA_REF_OPTION: nxt_s.speed_ref = option_ref;
      DNCA_REF_NET: nxt_s.speed_ref = s_ff.net_ref;
    endcase

    // Counters wrap; an event in the clearing cycle still counts
    for (int i = 0; i < 8; i++) begin
      if (cnt_inc[i]) begin
        nxt_s.cnt[i] = nxt_s.cnt[i] + 16'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.cfg <= `DNCA_CFG_RST;
      s_ff.timeout <= `DNCA_LINK_RST;
      s_ff.ser <= `DNCA_SER_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & (s_ff.bus == DNCA_IDLE);
  assign avs_readdata = s_ff.rdata;
  assign rsp_normal = s_ff.rsp_norm;
  assign rsp_exception = s_ff.rsp_exc;
  assign rsp_exc_code = s_ff.exc_code;
  assign run_fwd = s_ff.run_fwd;
  assign run_rev = s_ff.run_rev;
  assign speed_ref = s_ff.speed_ref;
  assign drive_reset = s_ff.rst_req;
  assign essential_services_override = s_ff.ovr_active;
  assign station_address = s_ff.ser[7:0];
  assign baud_select = s_ff.ser[11:8];
  assign parity_select = s_ff.ser[13:12];
endmodule

// [design/dnca_defines.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes 32-bit Avalon-MM byte addressing, one register per aligned word
`ifndef DNCA_DEFINES_SVH
`define DNCA_DEFINES_SVH
`define DNCA_A_CFG 8'h00
`define DNCA_A_LINK 8'h04
`define DNCA_A_SER 8'h08
`define DNCA_A_STAT 8'h0C
`define DNCA_A_SPD 8'h10
`define DNCA_A_DI 8'h14
`define DNCA_A_CNT 8'h20
`define DNCA_CFG_RUN_SRC 0
`define DNCA_CFG_LREF 1
`define DNCA_CFG_RREF 3
`define DNCA_CFG_OVR_TERM 5
`define DNCA_CFG_TH_L 6
`define DNCA_CFG_TH_R 7
`define DNCA_CFG_CLR 8
`define DNCA_CFG_RST 8'h00
`define DNCA_SER_RST 14'h0001
`define DNCA_LINK_RST 16'h03E8
`define DNCA_EXC_ILL_FUNC 8'h01
`define DNCA_EXC_ILL_ADDR 8'h02
`define DNCA_TH_HOT_OHM 16'h0BB8
`define DNCA_TH_SHORT_OHM 16'h0064
`define DNCA_CLK_NS 40
`define DNCA_MS_NS 1000000
`define DNCA_MS_CYC (`DNCA_MS_NS / `DNCA_CLK_NS)
`define DNCA_C_RX 0
`define DNCA_C_ERR 1
`define DNCA_C_EXC 2
`define DNCA_C_SLV 3
`define DNCA_C_NORSP 4
`define DNCA_C_OVR 5
`define DNCA_C_BUF 6
`define DNCA_C_REC 7
`endif

// [design/dnca_link_watch.sv]
// Communication-loss watchdog: millisecond timebase and loss flag
// Assumes kick pulses once per valid packet exchanged
`timescale 1ns/1ps
`include "dnca_defines.svh"
module dnca_link_watch import dnca_pkg::*; #(
  parameter int MS_CYCLES = `DNCA_MS_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic kick,
  input wire logic [15:0] timeout_ms,
  output logic link_lost,
  output logic recovered
);
  dnca_watch_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rec = 1'h0;
    if (kick) begin
      nxt_s.pre = 25'h0;
      nxt_s.ms = 17'h0;
      nxt_s.lost = 1'h0;
      nxt_s.rec = s_ff.lost;
    end else begin
      if (s_ff.pre >= 25'(MS_CYCLES - 1)) begin
        nxt_s.pre = 25'h0;
        // Saturate so a long silence never wraps back to healthy
        if (s_ff.ms != 17'h1FFFF) begin
          nxt_s.ms = s_ff.ms + 17'h1;
        end
      end else begin
        nxt_s.pre = s_ff.pre + 25'h1;
      end
      if (s_ff.ms > {1'h0, timeout_ms}) begin
        nxt_s.lost = 1'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link_lost = s_ff.lost;
  assign recovered = s_ff.rec;
endmodule

// [design/dnca_opt_slot.sv]
// One extended-feature option slot: card detect, digital inputs, thermistor
// Assumes card inputs are synchronous to clock
`timescale 1ns/1ps
`include "dnca_defines.svh"
module dnca_opt_slot import dnca_pkg::*; #(
  parameter int NDI = 4,
  parameter logic [15:0] HOT_OHM = `DNCA_TH_HOT_OHM,
  parameter logic [15:0] SHORT_OHM = `DNCA_TH_SHORT_OHM
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic card_detect,
  input wire logic [NDI-1:0] di,
  input wire logic [15:0] th_ohms,
  input wire logic th_enable,
  input wire logic trip_clear,
  output logic card_present,
  output logic [NDI-1:0] di_level,
  output logic [NDI-1:0] di_rise,
  output logic [NDI-1:0] di_inv,
  output logic overtemp_trip,
  output logic short_trip
);
  dnca_slot_t s_ff, nxt_s;
  logic [3:0] rise_c;

  genvar g;
  generate
    for (g = 0; g < NDI; g++) begin : g_di
      assign rise_c[g] = di[g] & ~s_ff.level[g];
    end
  endgenerate

  always_comb begin
    nxt_s = s_ff;
    nxt_s.present = card_detect;
    // Data from an absent card reads idle
    nxt_s.level = card_detect ? 4'(di) : 4'h0;
    nxt_s.rise = card_detect ? rise_c : 4'h0;
    if (trip_clear) begin
      nxt_s.hot = 1'h0;
      nxt_s.short_trip = 1'h0;
    end
    // Trip sets after the clear so a fresh fault is never lost
    if (s_ff.present && th_enable && th_ohms > HOT_OHM) begin
      nxt_s.hot = 1'h1;
    end
    if (s_ff.present && th_enable && th_ohms < SHORT_OHM) begin
      nxt_s.short_trip = 1'h1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign card_present = s_ff.present;
  assign di_level = s_ff.level[NDI-1:0];
  assign di_rise = s_ff.rise[NDI-1:0];
  assign di_inv = ~s_ff.level[NDI-1:0] & {NDI{s_ff.present}};
  assign overtemp_trip = s_ff.hot;
  assign short_trip = s_ff.short_trip;
endmodule

// [design/dnca_pkg.sv]
// Types shared by the network control arbiter modules
// Assumes nothing beyond the defines header
package dnca_pkg;
  typedef enum logic {DNCA_IDLE = 1'h0, DNCA_ANSWER = 1'h1} dnca_bus_t;
  typedef enum logic [1:0] {
    DNCA_REF_CONSOLE = 2'h0, DNCA_REF_ANALOG = 2'h1, DNCA_REF_OPTION = 2'h2, DNCA_REF_NET = 2'h3
  } dnca_ref_t;
  typedef enum logic [2:0] {
    DNCA_OBJ_RUN_FWD = 3'h0, DNCA_OBJ_RUN_REV = 3'h1, DNCA_OBJ_OVR = 3'h2,
    DNCA_OBJ_RESET = 3'h3, DNCA_OBJ_SPEED = 3'h4, DNCA_OBJ_LOCREM = 3'h5
  } dnca_obj_t;
  typedef struct packed {
    logic [24:0] pre;
    logic [16:0] ms;
    logic lost;
    logic rec;
  } dnca_watch_t;
  typedef struct packed {
    logic present;
    logic [3:0] level;
    logic [3:0] rise;
    logic hot;
    logic short_trip;
  } dnca_slot_t;
  typedef struct packed {
    dnca_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] cfg;
    logic [15:0] timeout;
    logic [13:0] ser;
    logic net_fwd;
    logic net_rev;
    logic net_ovr;
    logic [15:0] net_ref;
    logic run_fwd;
    logic run_rev;
    logic ovr_active;
    logic [15:0] speed_ref;
    logic rst_req;
    logic rsp_norm;
    logic rsp_exc;
    logic [7:0] exc_code;
    logic [7:0][15:0] cnt;
  } dnca_top_t;
endpackage

// [dv/dnca_arbiter_bench.sv]
// Self-checking bench of the network control arbiter
// Assumes the net master model as query source and a 25 MHz clock
`timescale 1ns/1ps
`include "dnca_defines.svh"
module dnca_arbiter_bench import dnca_pkg::*;;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, term_local = 1'b0, console_run_fwd = 1'b0, console_run_rev = 1'b0;
  logic term_run_fwd = 1'b0, term_run_rev = 1'b0, term_reset = 1'b0, internal_reset = 1'b0, term_override = 1'b0;
  logic [7:0] avs_address = 8'h00, card_di = 8'h00;
  logic [31:0] avs_writedata = 32'h0, card_th_ohms = 32'h0, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] card_detect = 2'h0;
  logic [15:0] console_ref = 16'h1111, analog_ref = 16'h2222, option_ref = 16'h3333;
  logic [15:0] refs [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  logic [15:0] cnt_exp [8] = '{16'h6, 16'h2, 16'h2, 16'h4, 16'h3, 16'h1, 16'h1, 16'h0};
  // Query flags, expected normal and exception, expected code
  logic [16:0] rows [6] = '{{7'h63, 2'h2, 8'h00}, {7'h13, 2'h0, 8'h00}, {7'h0B, 2'h0, 8'h00},
    {7'h07, 2'h0, 8'h00}, {7'h02, 2'h1, 8'h02}, {7'h01, 2'h1, 8'h01}};
  logic q_valid, q_parity_err, q_crc_err, q_broadcast, q_func_ok, q_addr_ok, q_write, q_overrun, q_buf_err;
  logic [2:0] q_obj;
  logic [15:0] q_wdata, speed_ref;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, rsp_normal, rsp_exception, run_fwd, run_rev, drive_reset, essential_services_override;
  logic link_lost, rst_seen;
  logic [7:0] rsp_exc_code, station_address, card_di_level, card_di_inv, card_di_rise;
  logic [3:0] baud_select;
  logic [1:0] parity_select, card_present, overtemp_trip, short_trip;
  int num_errors = 0, checks = 0, cycles = 0;
  dnca_arbiter #(.MS_CYCLES(10)) dnca_arbiter_i (.clock, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .q_valid, .q_parity_err, .q_crc_err, .q_broadcast, .q_func_ok,
    .q_addr_ok, .q_write, .q_obj, .q_wdata, .q_overrun, .q_buf_err, .rsp_normal, .rsp_exception, .rsp_exc_code,
    .term_local, .console_run_fwd, .console_run_rev, .term_run_fwd, .term_run_rev, .console_ref, .analog_ref,
    .option_ref, .term_reset, .internal_reset, .term_override, .card_detect, .card_di, .card_th_ohms, .run_fwd,
    .run_rev, .speed_ref, .drive_reset, .essential_services_override, .link_lost, .station_address, .baud_select,
    .parity_select, .card_present, .card_di_level, .card_di_rise, .card_di_inv, .overtemp_trip, .short_trip);
  dnca_net_master dnca_net_master_i (.clock, .q_valid, .q_parity_err, .q_crc_err, .q_broadcast, .q_func_ok,
    .q_addr_ok, .q_write, .q_obj, .q_wdata, .q_overrun, .q_buf_err);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    if (drive_reset === 1'b1) rst_seen <= 1'b1;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize;
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Design state moves by NBA, so a wake at a rising edge sees what that edge samples
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic look;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      dnca_net_master_i.send(rows[i][16:10], 1'b0, 3'h0, 16'h0000);
      @(negedge clock);
      chk("response", {rsp_normal, rsp_exception}, rows[i][9:8]);
      if (rows[i][8]) chk("exc_code", rsp_exc_code, rows[i][7:0]);
    end
    foreach (cnt_exp[i]) begin
      bus(1'b0, 8'(`DNCA_A_CNT + 4 * i), 32'h0, rd);
      chk("counter", rd, cnt_exp[i]);
    end
    bus(1'b0, `DNCA_A_LINK, 32'h0, rd);
    chk("link_reset", rd, 32'h3E8);
    bus(1'b0, 8'h40, 32'h0, rd);
    chk("hole", rd, 32'h0);
    bus(1'b1, `DNCA_A_SER, 32'h2305, rd);
    look;
    chk("serial", {parity_select, baud_select, station_address}, 32'h2305);
    @(posedge clock);
    term_run_fwd <= 1'b1;
    dnca_net_master_i.send(7'h03, 1'b1, DNCA_OBJ_RUN_REV, 16'h0001);
    look;
    chk("run_term", {run_fwd, run_rev}, 2'h2);
    bus(1'b1, `DNCA_A_CFG, 32'h1, rd);
    dnca_net_master_i.send(7'h03, 1'b1, DNCA_OBJ_LOCREM, 16'h0001);
    look;
    chk("run_net", {run_fwd, run_rev}, 2'h1);
    bus(1'b0, `DNCA_A_STAT, 32'h0, rd);
    chk("local", rd[1], 1'b0);
    @(posedge clock);
    term_local <= 1'b1;
    console_run_fwd <= 1'b1;
    dnca_net_master_i.send(7'h03, 1'b1, DNCA_OBJ_SPEED, 16'h4444);
    look;
    chk("run_local", {run_fwd, run_rev}, 2'h2);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `DNCA_A_CFG, 32'(s << 1), rd);
      look;
      chk("ref_local", speed_ref, refs[s]);
    end
    @(posedge clock);
    term_local <= 1'b0;
    bus(1'b1, `DNCA_A_CFG, 32'h18, rd);
    look;
    chk("ref_remote", speed_ref, 16'h4444);
    for (int s = 0; s < 3; s++) begin
      rst_seen = 1'b0;
      @(posedge clock);
      if (s == 0) term_reset <= 1'b1;
      else if (s == 1) internal_reset <= 1'b1;
      else dnca_net_master_i.send(7'h03, 1'b1, DNCA_OBJ_RESET, 16'h0001);
      @(posedge clock);
      term_reset <= 1'b0;
      internal_reset <= 1'b0;
      look;
      chk("reset", rst_seen, 1'b1);
    end
    dnca_net_master_i.send(7'h03, 1'b1, DNCA_OBJ_OVR, 16'h0001);
    look;
    chk("ovr_net", essential_services_override, 1'b1);
    dnca_net_master_i.alive = 1'b1;
    bus(1'b1, `DNCA_A_LINK, 32'h2, rd);
    repeat (100) @(posedge clock);
    @(negedge clock);
    chk("alive", link_lost, 1'b0);
    dnca_net_master_i.alive = 1'b0;
    repeat (100) @(posedge clock);
    @(negedge clock);
    chk("lost", {link_lost, essential_services_override}, 2'h2);
    bus(1'b1, `DNCA_A_CFG, 32'h20, rd);
    @(posedge clock);
    term_override <= 1'b1;
    look;
    chk("ovr_term", essential_services_override, 1'b1);
    dnca_net_master_i.send(7'h03, 1'b0, 3'h0, 16'h0000);
    repeat (15) @(posedge clock);
    @(negedge clock);
    chk("recover", link_lost, 1'b0);
    bus(1'b0, 8'(`DNCA_A_CNT + 28), 32'h0, rd);
    chk("recoveries", rd, 32'h1);
    repeat (60) @(posedge clock);
    @(negedge clock);
    chk("lost_again", link_lost, 1'b1);
    bus(1'b1, `DNCA_A_CFG, 32'h100, rd);
    bus(1'b0, `DNCA_A_CNT, 32'h0, rd);
    chk("cleared", rd, 32'h0);
    @(posedge clock);
    card_detect <= 2'h3;
    card_di <= 8'hA5;
    card_th_ohms <= {16'h0050, 16'h0BB8};
    bus(1'b1, `DNCA_A_CFG, 32'hC0, rd);
    look;
    chk("cards", {card_present, card_di_level, card_di_inv, overtemp_trip, short_trip}, {2'h3, 8'hA5, 8'h5A, 4'h2});
    @(posedge clock);
    card_th_ohms <= {16'h0050, 16'h0BB9};
    look;
    chk("hot", overtemp_trip, 2'h1);
    @(posedge clock);
    card_di <= 8'hFF;
    @(posedge clock);
    @(negedge clock);
    chk("rise", card_di_rise, 8'h5A);
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    look;
    chk("after_reset", {station_address, overtemp_trip}, {8'h01, 2'h0});
    summarize();
  end
endmodule

// [dv/dnca_arbiter_chk.sv]
// Port checker of the network control arbiter
// Assumes binding onto dnca_arbiter, one clock domain
`timescale 1ns/1ps
module dnca_arbiter_chk #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic q_valid,
  input wire logic q_parity_err,
  input wire logic q_crc_err,
  input wire logic q_broadcast,
  input wire logic q_func_ok,
  input wire logic q_addr_ok,
  input wire logic rsp_normal,
  input wire logic rsp_exception,
  input wire logic [7:0] rsp_exc_code,
  input wire logic term_local,
  input wire logic console_run_fwd,
  input wire logic run_fwd,
  input wire logic term_reset,
  input wire logic internal_reset,
  input wire logic drive_reset,
  input wire logic link_lost,
  input wire logic [1:0] card_detect,
  input wire logic [1:0] card_present,
  input wire logic [7:0] card_di_level,
  input wire logic [7:0] card_di_inv
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic clean;
  assign clean = q_valid && !q_parity_err && !q_crc_err;
  AST_NORMAL: assert property (clean && !q_broadcast && q_func_ok && q_addr_ok |=> rsp_normal && !rsp_exception)
    else $error("normal response missing");
  AST_DISCARD: assert property (q_valid && (q_parity_err || q_crc_err) |=> !rsp_normal && !rsp_exception)
    else $error("errored query answered");
  AST_EXCEPT: assert property (clean && !q_broadcast && q_func_ok && !q_addr_ok |=> rsp_exception && rsp_exc_code == 8'h02)
    else $error("exception response wrong");
  AST_BCAST: assert property (q_valid && q_broadcast |=> !rsp_normal && !rsp_exception)
    else $error("broadcast answered");
  AST_LOCAL_RUN: assert property (term_local |=> run_fwd == $past(console_run_fwd))
    else $error("local run not from console");
  AST_RESET: assert property (term_reset || internal_reset |=> drive_reset)
    else $error("reset request lost");
  AST_WAIT: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing wrong");
  AST_LINK: assert property (clean |-> ##[1:3] !link_lost)
    else $error("link loss not cleared by query");
  AST_INV: assert property (card_di_inv == (~card_di_level & {{4{card_present[1]}}, {4{card_present[0]}}}))
    else $error("complement inputs wrong");
  AST_DETECT: assert property (card_detect[0] |-> ##[1:2] card_present[0])
    else $error("card not detected");
endmodule
bind dnca_arbiter dnca_arbiter_chk #(.MS_CYCLES(MS_CYCLES)) dnca_arbiter_chk_i (.*);

// [dv/dnca_net_master.sv]
// Network master model, seen through the frame decoder's query pulses
// Assumes the arbiter samples the query fields, except overrun and buffer error, only with q_valid
`timescale 1ns/1ps
module dnca_net_master (
  input wire logic clock,
  output logic q_valid,
  output logic q_parity_err,
  output logic q_crc_err,
  output logic q_broadcast,
  output logic q_func_ok,
  output logic q_addr_ok,
  output logic q_write,
  output logic [2:0] q_obj,
  output logic [15:0] q_wdata,
  output logic q_overrun,
  output logic q_buf_err
);
  logic alive = 1'b0;
  initial begin
    {q_valid, q_parity_err, q_crc_err, q_broadcast, q_func_ok, q_addr_ok, q_write, q_overrun, q_buf_err} = '0;
    q_obj = 3'h0;
    q_wdata = 16'h0000;
  end
  // Flags: overrun, buffer, parity, crc, broadcast, function ok, object ok
  task automatic send(input logic [6:0] f, input logic wr, input logic [2:0] obj, input logic [15:0] d);
    @(posedge clock);
    q_valid <= 1'b1;
    {q_overrun, q_buf_err, q_parity_err, q_crc_err, q_broadcast, q_func_ok, q_addr_ok} <= f;
    q_write <= wr;
    q_obj <= obj;
    q_wdata <= d;
    @(posedge clock);
    // Stale object and data fields scrambled so nothing leans on them
    q_valid <= 1'b0;
    {q_overrun, q_buf_err, q_write} <= 3'h0;
    q_obj <= ~obj;
    q_wdata <= ~d;
  endtask
  // Keep-alive reads well inside the loss timeout
  always @(posedge clock) begin
    if (alive) begin
      repeat (4) @(posedge clock);
      send(7'h03, 1'b0, 3'h0, 16'h0000);
    end
  end
endmodule
